// ==== shared/rx_status_pkg.sv ====
`default_nettype none
package rx_status_pkg;
  // Register offsets on the serial control port
  localparam logic [6:0] PREAMBLE_LOW_ADDR = 7'h17;
  localparam logic [6:0] FAULT_FLAGS_ADDR  = 7'h18;
  localparam logic [6:0] FAULT_MASK_ADDR   = 7'h19;
  // Field positions in the fault flag and mask registers
  localparam int VALIDITY_BIT = 7;
  localparam int EMPHASIS_BIT = 6;
  localparam int NON_PCM_BIT  = 5;
  localparam int PREAMBLE_BIT = 4;
  localparam int CRC_BIT      = 3;
  localparam int ABSENT_BIT   = 2;
  localparam int CODING_BIT   = 1;
  localparam int LOCK_BIT     = 0;
  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'h00;
  // Flags that only report a change of state after a read
  localparam logic [7:0] LEVEL_FLAGS  = 8'h75;
  // Flags held until the register is read
  localparam logic [7:0] STICKY_FLAGS = 8'h0a;
endpackage : rx_status_pkg
`default_nettype wire

// ==== shared/flag_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Condition levels and events handed to the flag tracker
interface flag_if;
  logic [7:0] cond;
  logic [7:0] mask;
  logic       read_pulse;
  logic [7:0] flags;
  logic       irq;
  modport tracker (input cond, input mask, input read_pulse, output flags, output irq);
  modport owner   (output cond, output mask, output read_pulse, input flags, input irq);
endinterface : flag_if
`default_nettype wire

// ==== hw/flag_tracker.sv ====
`timescale 1ns/1ps
`default_nettype none
module flag_tracker (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  flag_if.tracker   fi
);
  logic [7:0] flags;
  logic [7:0] seen;
  logic [7:0] pend;
  logic [7:0] change;
  logic [7:0] next_flags;

  // Change of state for level flags, any event for sticky ones
  always_comb begin
    change = (fi.cond ^ seen) & rx_status_pkg::LEVEL_FLAGS;
    change = change | (fi.cond & rx_status_pkg::STICKY_FLAGS);
    change[rx_status_pkg::VALIDITY_BIT] = fi.cond[rx_status_pkg::VALIDITY_BIT]
      ^ seen[rx_status_pkg::VALIDITY_BIT];
  end

  // Level flags follow the line; sticky flags clear on read, set wins
  always_comb begin
    next_flags = (fi.cond & ~rx_status_pkg::STICKY_FLAGS);
    next_flags = next_flags | (fi.cond & rx_status_pkg::STICKY_FLAGS)
      | (flags & rx_status_pkg::STICKY_FLAGS & {8{~fi.read_pulse}});
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags <= rx_status_pkg::FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // Previous cycle's level, so a level flag raises an event only on a change
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      seen <= rx_status_pkg::FLAGS_RESET;
    end else begin
      seen <= fi.cond;
    end
  end

  // Pending events; a read drops them but a new event in that cycle stays
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend <= 8'h00;
    end else begin
      pend <= (pend & {8{~fi.read_pulse}}) | (change & fi.mask);
    end
  end

  assign fi.flags = flags;
  assign fi.irq   = |pend;

  chk_sticky_read_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fi.read_pulse && !fi.cond[rx_status_pkg::CRC_BIT]
    |=> !flags[rx_status_pkg::CRC_BIT]) else $error("crc flag not cleared");
  chk_sticky_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flags[rx_status_pkg::CODING_BIT] && !fi.read_pulse
    |=> flags[rx_status_pkg::CODING_BIT]) else $error("coding flag dropped");
  chk_lock_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 flags[rx_status_pkg::LOCK_BIT] == $past(fi.cond[rx_status_pkg::LOCK_BIT]))
    else $error("lock flag wrong");
  chk_masked_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fi.read_pulse && fi.mask == 8'h00 |=> !fi.irq) else $error("masked irq");
endmodule : flag_tracker
`default_nettype wire

// ==== hw/rx_fault_status.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Offset 0x17 reads the low byte of the second burst preamble while non-PCM, else zero.
// - In per-subframe non-PCM mode 0x17 instead holds the channel B first-preamble byte.
// - Bit 7 of 0x18 mirrors the received validity bit.
// - Bit 6 is set while the audio carries pre-emphasis.
// - After a read the emphasis flag stays and interrupts again only on change.
// - Bit 5 is set while channel status bit 1 (non-PCM) is set.
// - After a read the non-PCM flag interrupts again only on return to audio or type change.
// - Bit 4 is set when a burst preamble made the data non-PCM; its type is recorded.
// - After a read the preamble flag holds and interrupts only on change.
// - Bit 3 flags a channel-status CRC failure.
// - The CRC flag stays set until 0x18 is read; that read clears it unless a new CRC failure arrives in the same cycle.
// - Bit 1 is set on any biphase or parity error and held until 0x18 is read.
// - Bit 0 follows PLL lock and interrupts only on change after a read.
// - Mask at 0x19 uses the same bit positions; a 1 enables that flag's interrupt.
module rx_fault_status (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        validity_i,
  input  wire logic        emphasis_i,
  input  wire logic        non_pcm_i,
  input  wire logic [3:0]  non_pcm_kind_i,
  input  wire logic        preamble_found_i,
  input  wire logic [3:0]  preamble_type_i,
  input  wire logic        crc_fail_i,
  input  wire logic        input_absent_i,
  input  wire logic        coding_error_i,
  input  wire logic        pll_locked_i,
  input  wire logic        subframe_mode_i,
  input  wire logic [15:0] second_preamble_i,
  input  wire logic [15:0] chan_b_preamble_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic      [3:0]  preamble_type_o,
  output logic             irq_o
);
  flag_if fi ();

  logic [7:0] mask;
  logic [3:0] kind_seen;
  logic       kind_changed;
  logic [7:0] second_preamble_low_bits;
  logic [7:0] next_rdata;

  // Read strobe of the fault register drives all read side effects
  assign fi.read_pulse = reg_rd_i && (reg_addr_i == rx_status_pkg::FAULT_FLAGS_ADDR);

  // A change of non-PCM kind is folded in as a one-cycle toggle of the level
  assign fi.cond = {validity_i,
                    emphasis_i,
                    non_pcm_i & ~kind_changed,
                    preamble_found_i,
                    crc_fail_i,
                    input_absent_i,
                    coding_error_i,
                    pll_locked_i};
  assign fi.mask = mask;

  flag_tracker tracker (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .fi      (fi.tracker)
  );

  // Track the kind so a new non-PCM type re-arms the flag
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      kind_seen <= 4'h0;
    end else begin
      kind_seen <= non_pcm_kind_i;
    end
  end
  assign kind_changed = non_pcm_i && (kind_seen != non_pcm_kind_i);

  // Mask register, writable at its own offset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask <= rx_status_pkg::MASK_RESET;
    end else if (reg_wr_i && reg_addr_i == rx_status_pkg::FAULT_MASK_ADDR) begin
      mask <= reg_wdata_i;
    end
  end

  // Preamble type recorded when a burst preamble is seen
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      preamble_type_o <= 4'h0;
    end else if (preamble_found_i) begin
      preamble_type_o <= preamble_type_i;
    end
  end

  // Zero outside non-PCM so stale bursts never leak to software
  always_comb begin
    if (!non_pcm_i) begin
      second_preamble_low_bits = 8'h00;
    end else if (subframe_mode_i) begin
      second_preamble_low_bits = chan_b_preamble_i[15:8];
    end else begin
      second_preamble_low_bits = second_preamble_i[7:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr_i)
      rx_status_pkg::PREAMBLE_LOW_ADDR: next_rdata = second_preamble_low_bits;
      rx_status_pkg::FAULT_FLAGS_ADDR:  next_rdata = fi.flags;
      rx_status_pkg::FAULT_MASK_ADDR:   next_rdata = mask;
      default:                          next_rdata = 8'h00;
    endcase
  end

  // Data registered on the read strobe, held between reads
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  assign irq_o = fi.irq;

  chk_preamble_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == rx_status_pkg::PREAMBLE_LOW_ADDR && !non_pcm_i
    |=> reg_rdata_o == 8'h00) else $error("preamble byte not zero");
  chk_subframe_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == rx_status_pkg::PREAMBLE_LOW_ADDR && non_pcm_i
    && subframe_mode_i |=> reg_rdata_o == $past(chan_b_preamble_i[15:8]))
    else $error("subframe byte wrong");
  chk_irq_drop_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fi.read_pulse && $stable(fi.cond) && $past(fi.cond) == fi.cond && !kind_changed
    |=> !irq_o) else $error("irq not dropped by read");
  chk_mask_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == rx_status_pkg::FAULT_MASK_ADDR
    |=> mask == $past(reg_wdata_i)) else $error("mask not written");
endmodule : rx_fault_status
`default_nettype wire

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host on the control port: one-cycle strobes, address valid only with its strobe
module host_model (
  input  wire logic       clk_i,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [6:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial begin
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    addr_o  = 7'h00;
    wdata_o = 8'h00;
  end

  // Edge gap first, so back-to-back calls never drive a strobe twice at one edge
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    rd_o    <= !w;
    wr_o    <= w;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    rd_o    <= 1'b0;
    wr_o    <= 1'b0;
    // Released lines invert so a stale address never looks valid
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : acc
endmodule : host_model
`default_nettype wire

// ==== testbench/spdif_rx_error_status_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_error_status_bench;
  localparam logic [6:0] FA = rx_status_pkg::FAULT_FLAGS_ADDR;
  localparam logic [6:0] MA = rx_status_pkg::FAULT_MASK_ADDR;
  localparam logic [6:0] PA = rx_status_pkg::PREAMBLE_LOW_ADDR;
  logic        clk_i, rst_n_i, sub, rd, wr, irq, rd_d;
  logic [7:0]  cond, wdata, rdata, stk;
  logic [3:0]  kind, ptype, type_o;
  logic [15:0] pre2, preb;
  logic [6:0]  addr;
  logic [7:0]  exp_q[$];
  int          fails, samples_checked, cyc;
  int          lv[5] = '{7, 6, 4, 2, 0};

  host_model host (.clk_i(clk_i), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
  rx_fault_status uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .validity_i(cond[7]),
    .emphasis_i(cond[6]), .non_pcm_i(cond[5]), .non_pcm_kind_i(kind),
    .preamble_found_i(cond[4]), .preamble_type_i(ptype), .crc_fail_i(cond[3]),
    .input_absent_i(cond[2]), .coding_error_i(cond[1]), .pll_locked_i(cond[0]),
    .subframe_mode_i(sub), .second_preamble_i(pre2), .chan_b_preamble_i(preb),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .preamble_type_o(type_o), .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic cmp_data(input logic [7:0] got, input logic [7:0] want);
    samples_checked++;
    if (got !== want) begin
      fails++;
      $display("mismatch t=%0t got %h want %h", $time, got, want);
    end
  endtask : cmp_data
  task automatic cmp_irq(input logic got, input logic want);
    cmp_data({7'h00, got}, {7'h00, want});
  endtask : cmp_irq
  task automatic results();
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic rd_exp(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask : rd_exp
  // Sticky bits expected once, then gone after the read
  task automatic rdf();
    rd_exp(FA, (cond & 8'hf5) | stk);
    stk = 8'h00;
  endtask : rdf
  task automatic irq_is(input logic e);
    tick(1);
    @(negedge clk_i);
    cmp_irq(irq, e);
    @(posedge clk_i);
  endtask : irq_is
  task automatic pulse_sticky();
    cond <= cond | 8'h0a;
    @(posedge clk_i);
    cond <= cond & 8'hf5;
    stk = 8'h0a;
  endtask : pulse_sticky

  // Read data lands one cycle after the strobe edge
  always @(posedge clk_i) rd_d <= rd;
  always @(negedge clk_i) begin
    if (rd_d && exp_q.size() > 0) cmp_data(rdata, exp_q.pop_front());
  end

  // Hang guard, far above the roughly 110 cycles the sequence needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end

  initial begin
    {rst_n_i, sub, cond, kind, ptype, pre2, preb, stk, rd_d} = '0;
    {fails, samples_checked, cyc} = '0;
    void'($urandom(32'hbcc6));
    tick(12);
    rst_n_i <= 1'b1;
    rdf();
    rd_exp(MA, 8'h00);
    host.acc(1'b1, MA, 8'hff);
    rd_exp(MA, 8'hff);
    host.acc(1'b1, FA, 8'hff);
    rdf();
    rd_exp(7'h20, 8'h00);
    pre2 <= 16'($urandom);
    preb <= 16'($urandom);
    tick(2);
    rd_exp(PA, 8'h00);
    cond <= 8'h20;
    tick(3);
    rd_exp(PA, pre2[7:0]);
    sub <= 1'b1;
    tick(2);
    rd_exp(PA, preb[15:8]);
    rdf();
    irq_is(1'b0);
    foreach (lv[i]) begin
      ptype <= 4'($urandom);
      cond[lv[i]] <= 1'b1;
      irq_is(1'b1);
      rdf();
      irq_is(1'b0);
      rdf();
    end
    cmp_data({4'h0, type_o}, {4'h0, ptype});
    cond[6] <= 1'b0;
    irq_is(1'b1);
    rdf();
    kind <= kind + 4'h1;
    tick(2);
    irq_is(1'b1);
    rdf();
    pulse_sticky();
    irq_is(1'b1);
    rdf();
    irq_is(1'b0);
    rdf();
    host.acc(1'b1, MA, 8'h00);
    // Sticky pulse and loss of lock in one assignment, so cond is written once per step
    cond <= (cond | 8'h0a) & 8'hfe;
    @(posedge clk_i);
    cond <= cond & 8'hf5;
    stk = 8'h0a;
    irq_is(1'b0);
    rdf();
    tick(3);
    results();
  end
endmodule : spdif_rx_error_status_bench
`default_nettype wire
